// [hw/nand_host.sv]
// Host controller that runs read, program, erase, status, identification and reset cycles on a NAND flash
module nand_host (
  // Clock and reset
  input  wire logic                             clk,
  input  wire logic                             rst,
  // User request
  input  wire logic                             req_valid,
  output logic                                  req_ready,
  input  wire nand_host_pkg::req_t              req,
  input  wire logic                             wr_protect_n,
  // Write data stream
  input  wire logic [7:0]                       wdata,
  output logic                                  wdata_take,
  // Read data stream
  output logic [7:0]                            rdata_ff,
  output logic                                  rvalid_ff,
  output logic                                  done_ff,
  // Flash pins
  output nand_host_pkg::pins_t                  pins_ff,
  input  wire logic [7:0]                       io_in,
  input  wire logic                             ready_busy_in
);

  // *************************************************************
  // Pin input synchronisers
  // *************************************************************
  logic [7:0] io_s1_ff, io_s2_ff;   // Bus sampled twice before use
  logic       rb_s1_ff, rb_s2_ff;   // Ready/busy line, open drain pulled up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      io_s1_ff <= 8'h00;
      io_s2_ff <= 8'h00;
      rb_s1_ff <= 1'b1;
      rb_s2_ff <= 1'b1;
    end else begin
      io_s1_ff <= io_in;
      io_s2_ff <= io_s1_ff;
      rb_s1_ff <= ready_busy_in;
      rb_s2_ff <= rb_s1_ff;
    end
  end

  // *************************************************************
  // Sequencer
  // *************************************************************
  typedef enum logic [3:0] {
    S_IDLE, S_CMD, S_ADDR, S_DATA, S_CMD2, S_WAIT, S_RDAT, S_DONE
  } state_t;

  state_t                                   state_ff, nxt_state;
  nand_host_pkg::req_t                      cur_ff, nxt_cur;
  logic [1:0]                               acnt_ff, nxt_acnt;    // Address cycle index
  logic [nand_host_pkg::BYTE_CNT_W-1:0]     bcnt_ff, nxt_bcnt;    // Data bytes moved
  logic [nand_host_pkg::PH_W-1:0]           ph_ff, nxt_ph;        // Phase timer
  logic                                     half_ff, nxt_half;    // 0: strobe low, 1: strobe high
  logic                                     busy_seen_ff, nxt_busy_seen;
  nand_host_pkg::pins_t                     nxt_pins;
  logic [7:0]                               nxt_rdata;
  logic                                     nxt_rvalid, nxt_done;
  logic                                     step;                 // One strobe cycle completes

  // First command byte of each operation
  function automatic logic [7:0] first_cmd(input nand_host_pkg::op_t op);
    unique case (op)
      nand_host_pkg::OP_READ:   first_cmd = nand_host_pkg::CMD_READ;
      nand_host_pkg::OP_PROG:   first_cmd = nand_host_pkg::CMD_PROG;
      nand_host_pkg::OP_ERASE:  first_cmd = nand_host_pkg::CMD_ERASE;
      nand_host_pkg::OP_STATUS: first_cmd = nand_host_pkg::CMD_STATUS;
      nand_host_pkg::OP_ID:     first_cmd = nand_host_pkg::CMD_ID;
      nand_host_pkg::OP_RESET:  first_cmd = nand_host_pkg::CMD_RESET;
      default:                  first_cmd = nand_host_pkg::CMD_STATUS;
    endcase
  endfunction

  // Number of address cycles per operation
  function automatic logic [1:0] addr_cycles(input nand_host_pkg::op_t op);
    unique case (op)
      nand_host_pkg::OP_READ, nand_host_pkg::OP_PROG: addr_cycles = 2'd3;
      nand_host_pkg::OP_ERASE:                        addr_cycles = 2'd2;
      nand_host_pkg::OP_ID:                           addr_cycles = 2'd1;
      default:                                        addr_cycles = 2'd0;
    endcase
  endfunction

  // Address byte for a cycle; erase starts at the row byte
  function automatic logic [7:0] addr_byte(input nand_host_pkg::req_t r, input logic [1:0] idx);
    logic [1:0] k;
    k = (r.op == nand_host_pkg::OP_ERASE) ? idx + 2'd1 : idx;
    unique case (k)
      2'd0:    addr_byte = r.addr[7:0];
      2'd1:    addr_byte = r.addr[nand_host_pkg::ROW_LSB +: 8];
      2'd2:    addr_byte = {5'h00, r.addr[nand_host_pkg::HI_LSB +: nand_host_pkg::HI_W]};
      default: addr_byte = 8'h00;
    endcase
  endfunction

  assign step = half_ff && (ph_ff == nand_host_pkg::PH_W'(nand_host_pkg::PHASE_CYC - 1));
  // Only new operations wait for idle; keeps all commands, reset included, out of busy time
  assign req_ready  = (state_ff == S_IDLE) && rb_s2_ff;
  // Byte is taken at the edge that puts it on the bus, so the source may step on right then
  assign wdata_take = step && (nxt_state == S_DATA);

  // Next-state logic
  always_comb begin
    nxt_state     = state_ff;
    nxt_cur       = cur_ff;
    nxt_acnt      = acnt_ff;
    nxt_bcnt      = bcnt_ff;
    nxt_busy_seen = busy_seen_ff;
    nxt_pins      = pins_ff;
    nxt_rdata     = rdata_ff;
    nxt_rvalid    = 1'b0;
    nxt_done      = 1'b0;
    nxt_half      = half_ff;
    nxt_ph        = ph_ff + nand_host_pkg::PH_W'(1);
    nxt_pins.wp_n = wr_protect_n;
    if (ph_ff == nand_host_pkg::PH_W'(nand_host_pkg::PHASE_CYC - 1)) begin
      nxt_ph   = '0;
      nxt_half = ~half_ff;
    end
    unique case (state_ff)
      // Wait for a request; hold chip deselected and bus released
      S_IDLE: begin
        nxt_pins.ce_n    = 1'b1;
        nxt_pins.io_oe_n = 1'b1;
        nxt_ph           = '0;
        nxt_half         = 1'b0;
        if (req_valid && rb_s2_ff) begin
          nxt_cur        = req;
          nxt_acnt       = '0;
          nxt_bcnt       = '0;
          nxt_busy_seen  = 1'b0;
          nxt_pins.ce_n  = 1'b0;
          nxt_pins.cle   = 1'b1;
          nxt_pins.we_n  = 1'b0;
          nxt_pins.io_out  = first_cmd(req.op);
          nxt_pins.io_oe_n = 1'b0;
          nxt_state      = S_CMD;
        end
      end
      // Command, address and data bytes: raise write strobe, then move on
      S_CMD, S_ADDR, S_CMD2, S_DATA: begin
        if (ph_ff == nand_host_pkg::PH_W'(nand_host_pkg::PHASE_CYC - 1) && !half_ff)
          nxt_pins.we_n = 1'b1;
        if (step) begin
          nxt_pins.cle = 1'b0;
          nxt_pins.ale = 1'b0;
          if (state_ff == S_DATA)
            nxt_bcnt = bcnt_ff + 1'b1;
          if ((state_ff == S_CMD || state_ff == S_ADDR) &&
              (state_ff == S_CMD ? 2'd0 : acnt_ff + 2'd1) < addr_cycles(cur_ff.op)) begin
            nxt_acnt = (state_ff == S_CMD) ? 2'd0 : acnt_ff + 2'd1;
            nxt_pins.ale    = 1'b1;
            nxt_pins.we_n   = 1'b0;
            nxt_pins.io_out = addr_byte(cur_ff, nxt_acnt);
            nxt_state       = S_ADDR;
          end else if (cur_ff.op == nand_host_pkg::OP_PROG && state_ff != S_CMD2 &&
                       bcnt_ff + (state_ff == S_DATA) < cur_ff.len) begin
            nxt_pins.we_n   = 1'b0;
            nxt_pins.io_out = wdata;
            nxt_state       = S_DATA;
          end else if ((cur_ff.op == nand_host_pkg::OP_PROG || cur_ff.op == nand_host_pkg::OP_ERASE) &&
                       state_ff != S_CMD2) begin
            nxt_pins.cle    = 1'b1;
            nxt_pins.we_n   = 1'b0;
            nxt_pins.io_out = (cur_ff.op == nand_host_pkg::OP_PROG) ?
                              nand_host_pkg::CMD_PROG_GO : nand_host_pkg::CMD_ERASE_GO;
            nxt_state       = S_CMD2;
          end else begin
            nxt_pins.io_oe_n = 1'b1;
            nxt_state        = S_WAIT;
          end
        end
      end
      // Wait out busy; chip stays selected through program and erase
      S_WAIT: begin
        nxt_half = 1'b0;
        if (!rb_s2_ff)
          nxt_busy_seen = 1'b1;
        if (ph_ff == nand_host_pkg::PH_W'(nand_host_pkg::PHASE_CYC - 1) && (busy_seen_ff || rb_s2_ff)
            && rb_s2_ff) begin
          if (cur_ff.op == nand_host_pkg::OP_PROG || cur_ff.op == nand_host_pkg::OP_ERASE ||
              cur_ff.op == nand_host_pkg::OP_RESET || cur_ff.len == '0) begin
            nxt_state = S_DONE;
          end else begin
            nxt_bcnt               = '0;
            nxt_pins.read_strobe_n = 1'b0;
            nxt_state              = S_RDAT;
          end
        end
      end
      // Serial read: one byte per read strobe low pulse
      S_RDAT: begin
        if (ph_ff == nand_host_pkg::PH_W'(nand_host_pkg::PHASE_CYC - 1) && !half_ff) begin
          nxt_pins.read_strobe_n = 1'b1;
        end
        // Sample late: the bus needs two clocks through the synchroniser after the strobe fell
        if (step) begin
          nxt_rdata  = io_s2_ff;
          nxt_rvalid = 1'b1;
          nxt_bcnt   = bcnt_ff + 1'b1;
          if (bcnt_ff + 1'b1 < cur_ff.len)
            nxt_pins.read_strobe_n = 1'b0;
          else
            nxt_state = S_DONE;
        end
      end
      // Deselect, which ends any read, and report completion
      S_DONE: begin
        nxt_pins.ce_n = 1'b1;
        nxt_done      = 1'b1;
        nxt_state     = S_IDLE;
      end
      default: nxt_state = S_IDLE;
    endcase
  end

  // Register the sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff     <= S_IDLE;
      cur_ff       <= '0;
      acnt_ff      <= '0;
      bcnt_ff      <= '0;
      ph_ff        <= '0;
      half_ff      <= 1'b0;
      busy_seen_ff <= 1'b0;
      pins_ff      <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1, read_strobe_n: 1'b1,
                        wp_n: 1'b0, io_out: 8'h00, io_oe_n: 1'b1};
      rdata_ff     <= 8'h00;
      rvalid_ff    <= 1'b0;
      done_ff      <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      cur_ff       <= nxt_cur;
      acnt_ff      <= nxt_acnt;
      bcnt_ff      <= nxt_bcnt;
      ph_ff        <= nxt_ph;
      half_ff      <= nxt_half;
      busy_seen_ff <= nxt_busy_seen;
      pins_ff      <= nxt_pins;
      rdata_ff     <= nxt_rdata;
      rvalid_ff    <= nxt_rvalid;
      done_ff      <= nxt_done;
    end
  end

  // *************************************************************
  // Checks
  // *************************************************************
  a_we_ce_low: assert property (@(posedge clk) disable iff (rst)
    !pins_ff.we_n |-> !pins_ff.ce_n) else $error("write strobe low while deselected");
  a_cle_ale_excl: assert property (@(posedge clk) disable iff (rst)
    !(pins_ff.cle && pins_ff.ale)) else $error("command and address latch both high");
  a_no_rd_on_wr: assert property (@(posedge clk) disable iff (rst)
    !(pins_ff.we_n == 1'b0 && pins_ff.read_strobe_n == 1'b0)) else $error("both strobes low");
  a_bus_released: assert property (@(posedge clk) disable iff (rst)
    !pins_ff.read_strobe_n |-> pins_ff.io_oe_n) else $error("host drives bus during read");
  a_cmd_legal: assert property (@(posedge clk) disable iff (rst)
    (pins_ff.cle && !pins_ff.we_n) |-> pins_ff.io_out inside {8'h00, 8'hFF, 8'h80, 8'h10,
    8'h60, 8'hD0, 8'h70, 8'h90}) else $error("undefined command byte");
  a_erase_two: assert property (@(posedge clk) disable iff (rst)
    (state_ff == S_ADDR && cur_ff.op == nand_host_pkg::OP_ERASE) |-> acnt_ff < 2'd2)
    else $error("erase sent a third address cycle");
  // The edge that leaves reset still loads the reset value, so skip the cycle after it
  a_wp_follow: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> pins_ff.wp_n == $past(wr_protect_n)) else $error("write protect not forwarded");
  a_start_idle: assert property (@(posedge clk) disable iff (rst)
    (state_ff == S_IDLE && nxt_state == S_CMD) |-> rb_s2_ff) else $error("command issued while busy");

endmodule

// [hw/nand_host_pkg.sv]
// Package: command codes, address layout, timing counts and carrier types for the NAND host controller
package nand_host_pkg;

  // Command codes accepted by the flash
  localparam logic [7:0] CMD_READ      = 8'h00;
  localparam logic [7:0] CMD_RESET     = 8'hFF;
  localparam logic [7:0] CMD_PROG      = 8'h80;
  localparam logic [7:0] CMD_PROG_GO   = 8'h10;
  localparam logic [7:0] CMD_ERASE     = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO  = 8'hD0;
  localparam logic [7:0] CMD_STATUS    = 8'h70;
  localparam logic [7:0] CMD_ID        = 8'h90;

  // Address layout
  localparam int ADDR_W      = 19;
  localparam int ROW_LSB     = 8;
  localparam int HI_LSB      = 16;
  localparam int HI_W        = 3;
  localparam int FRAME_BYTES = 32;
  localparam int BYTE_CNT_W  = 6;

  // Strobe timing: each phase of a strobe pulse
  localparam int CLK_MHZ       = 25;
  localparam int PHASE_NS      = 80;
  localparam int PHASE_CYC_RAW = (PHASE_NS * CLK_MHZ + 999) / 1000;
  localparam int PHASE_CYC     = (PHASE_CYC_RAW < 1) ? 1 : PHASE_CYC_RAW;
  localparam int PH_W          = 4;

  // Operations the controller can run
  typedef enum logic [2:0] {
    OP_READ, OP_PROG, OP_ERASE, OP_STATUS, OP_ID, OP_RESET
  } op_t;

  // Request from the user side
  typedef struct packed {
    op_t                      op;
    logic [ADDR_W-1:0]        addr;
    logic [BYTE_CNT_W-1:0]    len;
  } req_t;

  // Flash pins driven by the controller
  typedef struct packed {
    logic       ce_n;
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       read_strobe_n;
    logic       wp_n;
    logic [7:0] io_out;
    logic       io_oe_n;
  } pins_t;

endpackage

// [tb/nand_flash_model.sv]
// Behavioural NAND flash device answering the host controller's strobe bus
module nand_flash_model #(
  parameter int         BUSY_NS = 1200,  // One shortened busy period for read, program, erase and reset
  parameter logic [7:0] ID0     = 8'hA5, // Identification bytes, values arbitrary
  parameter logic [7:0] ID1     = 8'h3C
) (
  // Strobes from the host
  input  wire logic       ce_n,
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       we_n,
  input  wire logic       read_strobe_n,
  input  wire logic       wp_n,
  // Shared data bus
  input  wire logic [7:0] io_bus,
  output logic      [7:0] dout,
  output logic            dout_en,
  // Open drain ready/busy: high pulls the wire low
  output logic            rb_pull
);
  logic [7:0]  mem [int];            // Sparse array, absent bytes read as erased
  logic [7:0]  fbuf [32];            // Frame data register
  logic [7:0]  cmd     = 8'hFF;      // Last latched command
  logic [18:0] addr    = 19'h0_0000; // Latched byte address
  logic [4:0]  col     = 5'h00;      // Column counter, wraps inside the frame
  logic        busy    = 1'b0;       // Internal busy state
  int          acnt    = 0;          // Address cycles since the last command
  int          bad_cmd = 0;          // Commands that the host must never send
  int          bad_seq = 0;          // Confirms after a wrong number of address cycles
  event        go;

  function automatic logic [7:0] rd(int k);
    return mem.exists(k) ? mem[k] : 8'hFF;
  endfunction

  // ************************************************************
  // Busy and output drivers
  // ************************************************************
  always @(go) begin
    busy = 1'b1;
    #(BUSY_NS);
    busy = 1'b0;
  end
  assign rb_pull = busy;
  assign dout_en = !ce_n && !read_strobe_n && !busy;
  // Deselect ends a read; a running program or erase keeps going
  always @(posedge ce_n) if (!busy) cmd = nand_host_pkg::CMD_RESET;

  // ************************************************************
  // Write strobe: command, address and data latching
  // ************************************************************
  always @(posedge we_n) begin
    int idx;
    int k;
    if (!ce_n && cle) begin
      if (!(io_bus inside {8'h00, 8'hFF, 8'h80, 8'h10, 8'h60, 8'hD0, 8'h70, 8'h90})) bad_cmd++;
      if (busy && !(io_bus inside {8'hFF, 8'h70})) bad_cmd++;
      if (io_bus == nand_host_pkg::CMD_PROG_GO && acnt != 3) bad_seq++;
      if (io_bus == nand_host_pkg::CMD_ERASE_GO && acnt != 2) bad_seq++;
      // High-voltage generator held off while protected
      if (io_bus == nand_host_pkg::CMD_PROG_GO && wp_n) begin
        for (int i = 0; i < 32; i++) begin
          k = {addr[18:5], 5'(i)};
          mem[k] = rd(k) & fbuf[i];
        end
        ->go;
      end
      if (io_bus == nand_host_pkg::CMD_ERASE_GO && wp_n) begin
        for (int i = 0; i < 4096; i++) mem.delete({addr[18:12], 12'(i)});
        ->go;
      end
      if (io_bus == nand_host_pkg::CMD_RESET) ->go;
      if (io_bus == nand_host_pkg::CMD_PROG) fbuf = '{default: 8'hFF};
      if (!(io_bus inside {8'h10, 8'hD0})) begin
        cmd  = io_bus;
        acnt = 0;
        col  = 5'h00;
      end
    end else if (!ce_n && ale) begin
      idx = (cmd == nand_host_pkg::CMD_ERASE) ? acnt + 1 : acnt;
      // Extra cycles and the identification byte change nothing
      if (cmd != nand_host_pkg::CMD_ID) begin
        if (idx == 0) addr[7:0] = io_bus;
        if (idx == 1) addr[15:8] = io_bus;
        if (idx == 2) addr[18:16] = io_bus[2:0];
        if (idx == 2) col = addr[4:0];
        if (idx == 2 && cmd == nand_host_pkg::CMD_READ) ->go;
      end
      acnt++;
    end else if (!ce_n && cmd == nand_host_pkg::CMD_PROG) begin
      fbuf[col] = io_bus;
      col++;
    end
  end

  // Read strobe fall puts the next byte out and steps the column
  always @(negedge read_strobe_n) if (!ce_n && !busy) begin
    case (cmd)
      nand_host_pkg::CMD_STATUS: dout = {wp_n, 1'b1, 6'h00};
      nand_host_pkg::CMD_ID:     dout = col[0] ? ID1 : ID0;
      default:                   dout = rd({addr[18:5], col});
    endcase
    col++;
  end
endmodule

// [tb/nand_host_tb.sv]
// Self-checking bench: NAND host controller against the behavioural flash model
module nand_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk = 1'b0, rst = 1'b1, req_valid = 1'b0, wr_protect_n = 1'b1, take_seen = 1'b0;
  logic                 req_ready, wdata_take, rvalid_ff, done_ff, dout_en, rb_pull;
  logic [7:0]           wdata = 8'h00, last_io = 8'h00, rdata_ff, io_bus, dout;
  nand_host_pkg::req_t  req = '0;
  nand_host_pkg::pins_t pins;
  logic [7:0]           wbuf [32]; // Program bytes of the current operation
  logic [7:0]           rq [$];    // Bytes read back by the current operation
  logic [7:0]           shadow [int];
  int                   failures = 0, samples_checked = 0, widx = 0;

  always #20 clk = ~clk;
  // Released bus toggles, so a stale byte never reads as valid
  assign io_bus = !pins.io_oe_n ? pins.io_out : dout_en ? dout : ~last_io;
  always @(posedge clk) last_io <= io_bus;
  always @(negedge clk) take_seen <= wdata_take;
  always @(posedge clk) if (take_seen === 1'b1) begin
    widx  <= widx + 1;
    wdata <= wbuf[(widx + 1) % 32];
  end
  always @(negedge clk) if (rvalid_ff === 1'b1) rq.push_back(rdata_ff);

  nand_host u_nand_host (.clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .wr_protect_n(wr_protect_n), .wdata(wdata), .wdata_take(wdata_take), .rdata_ff(rdata_ff),
    .rvalid_ff(rvalid_ff), .done_ff(done_ff), .pins_ff(pins), .io_in(io_bus), .ready_busy_in(!rb_pull));
  nand_flash_model u_nand_flash_model (.ce_n(pins.ce_n), .cle(pins.cle), .ale(pins.ale), .we_n(pins.we_n),
    .read_strobe_n(pins.read_strobe_n), .wp_n(pins.wp_n), .io_bus(io_bus), .dout(dout), .dout_en(dout_en),
    .rb_pull(rb_pull));

  // ************************************************************
  // Comparison, expectation and bus tasks
  // ************************************************************
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [7:0] exp_b(int k);
    return shadow.exists(k) ? shadow[k] : 8'hFF;
  endfunction
  // Request held until taken, then bounded wait for completion
  task automatic run(nand_host_pkg::op_t o, logic [18:0] a, logic [5:0] n);
    int t;
    rq.delete();
    @(posedge clk);
    req_valid <= 1'b1;
    req       <= '{o, a, n};
    t = 0;
    do @(negedge clk); while (req_ready !== 1'b1 && ++t < 5000);
    @(posedge clk);
    req_valid <= 1'b0;
    t = 0;
    do @(negedge clk); while (done_ff !== 1'b1 && ++t < 5000);
    check("done", {7'h00, done_ff}, 8'h01);
  endtask
  task automatic prog(logic [18:0] a, int n);
    int k;
    for (int i = 0; i < 32; i++) wbuf[i] = 8'($urandom);
    @(posedge clk);
    widx  <= 0;
    wdata <= wbuf[0];
    if (wr_protect_n) for (int i = 0; i < n; i++) begin
      k = {a[18:5], 5'(a[4:0] + i)};
      shadow[k] = exp_b(k) & wbuf[i];
    end
    run(nand_host_pkg::OP_PROG, a, 6'(n));
  endtask
  task automatic readback(logic [18:0] a);
    run(nand_host_pkg::OP_READ, a, 6'd32);
    check("read count", 8'(rq.size()), 8'h20);
    for (int i = 0; i < 32; i++) check("read byte", rq[i], exp_b({a[18:5], 5'(a[4:0] + i)}));
  endtask
  task automatic test_done;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ************************************************************
  // Test sequence and watchdog
  // ************************************************************
  initial begin
    #1_000_000;
    failures++;
    test_done();
  end
  initial begin
    int a;
    void'($urandom(32'h337b_197e));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    run(nand_host_pkg::OP_STATUS, 19'h0_0000, 6'd1);
    check("status", rq[0], 8'hC0);
    run(nand_host_pkg::OP_ID, 19'h0_0000, 6'd2);
    check("id first", rq[0], u_nand_flash_model.ID0);
    check("id second", rq[1], u_nand_flash_model.ID1);
    run(nand_host_pkg::OP_RESET, 19'h0_0000, 6'd0);
    run(nand_host_pkg::OP_STATUS, 19'h0_0000, 6'd1);
    check("status after reset", rq[0], 8'hC0);
    $display("test status_id_reset done");
    // First pass hits the top block and a full frame
    for (int r = 0; r < 5; r++) begin
      a = (r == 0) ? 32'h0007_FFE0 : $urandom;
      run(nand_host_pkg::OP_ERASE, a[18:0], 6'd0);
      for (int i = 0; i < 4096; i++) shadow.delete({a[18:12], 12'(i)});
      prog(a[18:0], (r == 0) ? 32 : 1 + $urandom % 32);
      prog(a[18:0] ^ 19'h0_0007, 4);
      readback(a[18:0]);
    end
    $display("test erase_program_read done");
    @(posedge clk);
    wr_protect_n <= 1'b0;
    prog(a[18:0], 16);
    check("protect pin", {7'h00, pins.wp_n}, 8'h00);
    run(nand_host_pkg::OP_ERASE, a[18:0], 6'd0);
    @(posedge clk);
    wr_protect_n <= 1'b1;
    readback(a[18:0]);
    $display("test write_protect done");
    check("illegal commands", 8'(u_nand_flash_model.bad_cmd), 8'h00);
    check("address cycle counts", 8'(u_nand_flash_model.bad_seq), 8'h00);
    test_done();
  end
endmodule
